// *** inc/gdm_pkg.sv ***
// constants and types shared by the gate drive mode decoder
package gdm_pkg;
	localparam int PHASES = 3;
	localparam int DT_W = 8;
	localparam int CLK_PERIOD_NS = 8;
	localparam logic [2:0] MODE_SIX = 3'h0;
	localparam logic [2:0] MODE_THREE = 3'h1;
	localparam logic [2:0] MODE_SINGLE = 3'h2;
	localparam logic [2:0] MODE_HALL = 3'h3;
	localparam logic [2:0] MODE_HALL_ALT = 3'h4;
	localparam logic [2:0] COMM_STOP = 3'h0;
	localparam logic [2:0] COMM_AC = 3'h1;
	localparam logic [2:0] COMM_CB = 3'h2;
	localparam logic [2:0] COMM_AB = 3'h3;
	localparam logic [2:0] COMM_BA = 3'h4;
	localparam logic [2:0] COMM_BC = 3'h5;
	localparam logic [2:0] COMM_CA = 3'h6;
	localparam logic [2:0] COMM_ALIGN = 3'h7;
	localparam int DT_MIN_NS = 40;
	localparam logic [DT_W-1:0] DT_MIN_CYC =
		DT_W'((DT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam int BRAKE_ALT_NS = 10000;
	localparam int ALT_W = 11;
	localparam logic [ALT_W-1:0] BRAKE_ALT_CYC = ALT_W'(BRAKE_ALT_NS / CLK_PERIOD_NS);
	localparam logic [ALT_W-1:0] ALT_CNT_RST = 11'h000;
	localparam logic [DT_W-1:0] DT_CNT_RST = 8'h00;
	localparam logic [2:0] GATES_RST = 3'h0;
	typedef enum logic [1:0] {
		BRK_ALL_LOW = 2'b00,
		BRK_ALL_HIGH = 2'b01,
		BRK_ALTERNATE = 2'b10,
		BRK_HIZ = 2'b11
	} gdm_brake_t;
	typedef enum logic [1:0] {
		ROLE_OFF = 2'b00,
		ROLE_PWM = 2'b01,
		ROLE_LOW_ON = 2'b10
	} gdm_role_t;
	typedef enum logic [2:0] {
		OP_IDLE = 3'b000,
		OP_SIX = 3'b001,
		OP_THREE = 3'b010,
		OP_SINGLE = 3'b011,
		OP_HALL = 3'b100,
		OP_BRAKE = 3'b101
	} gdm_op_t;
endpackage

// *** inc/gdm_gate_if.sv ***
// gate requests, dead times and resulting gate levels of the three phases
`timescale 1ns/10ps
interface gdm_gate_if;
	logic [2:0] req_hi;
	logic [2:0] req_lo;
	logic [7:0] deadtime_rising;
	logic [7:0] deadtime_falling;
	logic [2:0] gate_hi;
	logic [2:0] gate_lo;
	logic [2:0] node_float;
	modport ctl (
		output req_hi, req_lo, deadtime_rising, deadtime_falling,
		input gate_hi, gate_lo, node_float
	);
	modport drv (
		input req_hi, req_lo, deadtime_rising, deadtime_falling,
		output gate_hi, gate_lo, node_float
	);
endinterface

// *** hw/gdm_deadtime.sv ***
// dead time insertion for the three half bridges
`timescale 1ns/10ps
module gdm_deadtime (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	gdm_gate_if.drv gate
);
	typedef struct packed {
		logic [2:0] hi;
		logic [2:0] lo;
		logic [2:0] flt;
		logic [2:0][7:0] hi_off;
		logic [2:0][7:0] lo_off;
	} gdm_dt_state_t;

	gdm_dt_state_t s;
	gdm_dt_state_t next_s;

	always_comb begin
		next_s = s;
		for (int i = 0; i < gdm_pkg::PHASES; i++) begin
			// off-time counters saturate so long idle periods never wrap
			next_s.lo_off[i] = s.lo[i] ? gdm_pkg::DT_CNT_RST :
				(&s.lo_off[i] ? s.lo_off[i] : s.lo_off[i] + 8'h01);
			next_s.hi_off[i] = s.hi[i] ? gdm_pkg::DT_CNT_RST :
				(&s.hi_off[i] ? s.hi_off[i] : s.hi_off[i] + 8'h01);
			// a gate turns on only once its partner has been off long enough
			next_s.hi[i] = gate.req_hi[i] & ~gate.req_lo[i] & ~s.lo[i] &
				(s.lo_off[i] >= gate.deadtime_rising);
			next_s.lo[i] = gate.req_lo[i] & ~gate.req_hi[i] & ~s.hi[i] &
				(s.hi_off[i] >= gate.deadtime_falling);
			next_s.flt[i] = ~next_s.hi[i] & ~next_s.lo[i];
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s <= '{hi: gdm_pkg::GATES_RST, lo: gdm_pkg::GATES_RST, flt: 3'h7,
				hi_off: '0, lo_off: '0};
		end else begin
			s <= next_s;
		end
	end

	assign gate.gate_hi = s.hi;
	assign gate.gate_lo = s.lo;
	assign gate.node_float = s.flt;
endmodule

// *** hw/gdm_brake_alt.sv ***
// divider that paces the alternating brake pattern
`timescale 1ns/10ps
module gdm_brake_alt (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic run_i,
	output logic alt_phase_o
);
	typedef struct packed {
		logic [10:0] cnt;
		logic phase;
	} gdm_alt_state_t;

	gdm_alt_state_t s;
	gdm_alt_state_t next_s;

	always_comb begin
		next_s = s;
		if (!run_i) begin
			// restart on the low side so every brake begins the same way
			next_s.cnt = gdm_pkg::ALT_CNT_RST;
			next_s.phase = 1'b0;
		end else if (s.cnt == gdm_pkg::BRAKE_ALT_CYC - 11'h001) begin
			next_s.cnt = gdm_pkg::ALT_CNT_RST;
			next_s.phase = ~s.phase;
		end else begin
			next_s.cnt = s.cnt + 11'h001;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s <= '{cnt: gdm_pkg::ALT_CNT_RST, phase: 1'b0};
		end else begin
			s <= next_s;
		end
	end

	assign alt_phase_o = s.phase;
endmodule

// *** hw/gdm_mode_decoder.sv ***
// input mode decoder of the three phase gate driver
// Contract
// - mode 0 selects six input operation
// - mode 1 selects three input operation
// - mode 2 selects single input commutation
// - two hall single input variants also selectable
// - six input: decode each phase pair
// - six input: enforce device minimum dead time
// - brake low overrides all pwm inputs
// - brake pattern: low, high, alternate, hiz
// - three input: low side is complement
// - three input: low input high floats phase
// - three input: rise and fall dead times
// - single input: phase a pwm reproduced
// - single input: inputs choose commutation state
// - single input: programmed dead time inserted
// - commutation code table incl align and stop
// - freewheel select: active or diode freewheeling
`timescale 1ns/10ps
module gdm_mode_decoder (
	input wire logic clk_sys_i,
	input wire logic nrst_i,
	input wire logic [2:0] drive_mode_select_i,
	input wire logic brake_request_n_i,
	input wire logic [1:0] brake_pattern_i,
	input wire logic freewheel_select_i,
	input wire logic [7:0] deadtime_rising_i,
	input wire logic [7:0] deadtime_falling_i,
	input wire logic [2:0] high_side_pwm_in_i,
	input wire logic [2:0] low_side_pwm_in_i,
	output logic [2:0] high_gate_out_o,
	output logic [2:0] low_gate_out_o,
	output logic [2:0] phase_node_float_o,
	output logic [2:0] op_state_o,
	output logic [3:0] comm_step_o
);
	typedef struct packed {
		gdm_pkg::gdm_op_t op;
		logic [2:0] req_hi;
		logic [2:0] req_lo;
		logic [7:0] deadtime_rising;
		logic [7:0] deadtime_falling;
		logic [3:0] step;
	} gdm_dec_state_t;

	gdm_dec_state_t s;
	gdm_dec_state_t next_s;
	logic rst_meta;
	logic rst_n;
	logic alt_phase;
	logic [5:0] roles;

	gdm_gate_if gate_if ();

	// phase roles {c, b, a} for a commutation code and the phase c step bit
	function automatic logic [5:0] comm_roles(input logic [2:0] code, input logic step);
		logic [5:0] r;
		r = {gdm_pkg::ROLE_OFF, gdm_pkg::ROLE_OFF, gdm_pkg::ROLE_OFF};
		case (code)
			// the step bit selects the state between the previous and this one
			gdm_pkg::COMM_AB: begin
				r = step ? {gdm_pkg::ROLE_LOW_ON, gdm_pkg::ROLE_LOW_ON, gdm_pkg::ROLE_PWM} :
					{gdm_pkg::ROLE_OFF, gdm_pkg::ROLE_LOW_ON, gdm_pkg::ROLE_PWM};
			end
			gdm_pkg::COMM_CB: begin
				r = step ? {gdm_pkg::ROLE_PWM, gdm_pkg::ROLE_LOW_ON, gdm_pkg::ROLE_PWM} :
					{gdm_pkg::ROLE_PWM, gdm_pkg::ROLE_LOW_ON, gdm_pkg::ROLE_OFF};
			end
			gdm_pkg::COMM_CA: begin
				r = step ? {gdm_pkg::ROLE_PWM, gdm_pkg::ROLE_LOW_ON, gdm_pkg::ROLE_LOW_ON} :
					{gdm_pkg::ROLE_PWM, gdm_pkg::ROLE_OFF, gdm_pkg::ROLE_LOW_ON};
			end
			gdm_pkg::COMM_BA: begin
				r = step ? {gdm_pkg::ROLE_PWM, gdm_pkg::ROLE_PWM, gdm_pkg::ROLE_LOW_ON} :
					{gdm_pkg::ROLE_OFF, gdm_pkg::ROLE_PWM, gdm_pkg::ROLE_LOW_ON};
			end
			gdm_pkg::COMM_BC: begin
				r = step ? {gdm_pkg::ROLE_LOW_ON, gdm_pkg::ROLE_PWM, gdm_pkg::ROLE_LOW_ON} :
					{gdm_pkg::ROLE_LOW_ON, gdm_pkg::ROLE_PWM, gdm_pkg::ROLE_OFF};
			end
			gdm_pkg::COMM_AC: begin
				r = step ? {gdm_pkg::ROLE_LOW_ON, gdm_pkg::ROLE_PWM, gdm_pkg::ROLE_PWM} :
					{gdm_pkg::ROLE_LOW_ON, gdm_pkg::ROLE_OFF, gdm_pkg::ROLE_PWM};
			end
			gdm_pkg::COMM_ALIGN: begin
				r = {gdm_pkg::ROLE_LOW_ON, gdm_pkg::ROLE_LOW_ON, gdm_pkg::ROLE_PWM};
			end
			default: begin
				r = {gdm_pkg::ROLE_OFF, gdm_pkg::ROLE_OFF, gdm_pkg::ROLE_OFF};
			end
		endcase
		return r;
	endfunction

	// step index 0..11 of the commutation sequence, 14 align, 15 stop
	function automatic logic [3:0] comm_index(input logic [2:0] code, input logic step);
		logic [3:0] n;
		n = 4'hf;
		case (code)
			gdm_pkg::COMM_AB: begin
				n = step ? 4'hb : 4'h0;
			end
			gdm_pkg::COMM_CB: begin
				n = step ? 4'h1 : 4'h2;
			end
			gdm_pkg::COMM_CA: begin
				n = step ? 4'h3 : 4'h4;
			end
			gdm_pkg::COMM_BA: begin
				n = step ? 4'h5 : 4'h6;
			end
			gdm_pkg::COMM_BC: begin
				n = step ? 4'h7 : 4'h8;
			end
			gdm_pkg::COMM_AC: begin
				n = step ? 4'h9 : 4'ha;
			end
			gdm_pkg::COMM_ALIGN: begin
				n = 4'he;
			end
			default: begin
				n = 4'hf;
			end
		endcase
		return n;
	endfunction

	// reset is released through two flops so every flop leaves reset together
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	// commutation code is {low a, high b, low b}; high c is the twelve step bit
	always_comb begin
		roles = comm_roles({low_side_pwm_in_i[0], high_side_pwm_in_i[1],
			low_side_pwm_in_i[1]}, high_side_pwm_in_i[2]);
	end

	always_comb begin
		next_s = s;
		// operating state is chosen fresh every cycle; brake has priority
		if (!brake_request_n_i) begin
			next_s.op = gdm_pkg::OP_BRAKE;
		end else begin
			case (drive_mode_select_i)
				gdm_pkg::MODE_SIX: begin
					next_s.op = gdm_pkg::OP_SIX;
				end
				gdm_pkg::MODE_THREE: begin
					next_s.op = gdm_pkg::OP_THREE;
				end
				gdm_pkg::MODE_SINGLE: begin
					next_s.op = gdm_pkg::OP_SINGLE;
				end
				gdm_pkg::MODE_HALL, gdm_pkg::MODE_HALL_ALT: begin
					// hall decoding lives outside this block; gates stay off here
					next_s.op = gdm_pkg::OP_HALL;
				end
				default: begin
					next_s.op = gdm_pkg::OP_IDLE;
				end
			endcase
		end
		next_s.step = comm_index({low_side_pwm_in_i[0], high_side_pwm_in_i[1],
			low_side_pwm_in_i[1]}, high_side_pwm_in_i[2]);
		next_s.req_hi = 3'h0;
		next_s.req_lo = 3'h0;
		next_s.deadtime_rising = deadtime_rising_i;
		next_s.deadtime_falling = deadtime_falling_i;
		case (next_s.op)
			gdm_pkg::OP_SIX: begin
				// overlapping inputs decode to both off, never to both on
				next_s.req_hi = high_side_pwm_in_i & ~low_side_pwm_in_i;
				next_s.req_lo = low_side_pwm_in_i & ~high_side_pwm_in_i;
				// the controller inserts its own dead time; this is only a floor
				next_s.deadtime_rising = gdm_pkg::DT_MIN_CYC;
				next_s.deadtime_falling = gdm_pkg::DT_MIN_CYC;
			end
			gdm_pkg::OP_THREE: begin
				// a high low-side input floats the phase, as the truth table shows
				next_s.req_hi = high_side_pwm_in_i & ~low_side_pwm_in_i;
				next_s.req_lo = ~high_side_pwm_in_i & ~low_side_pwm_in_i;
				next_s.deadtime_rising = deadtime_rising_i;
				next_s.deadtime_falling = deadtime_falling_i;
			end
			gdm_pkg::OP_SINGLE: begin
				for (int i = 0; i < gdm_pkg::PHASES; i++) begin
					case (gdm_pkg::gdm_role_t'(roles[2*i +: 2]))
						gdm_pkg::ROLE_PWM: begin
							next_s.req_hi[i] = high_side_pwm_in_i[0];
							next_s.req_lo[i] = ~freewheel_select_i &
								~high_side_pwm_in_i[0];
						end
						gdm_pkg::ROLE_LOW_ON: begin
							next_s.req_lo[i] = 1'b1;
						end
						default: begin
							next_s.req_hi[i] = 1'b0;
							next_s.req_lo[i] = 1'b0;
						end
					endcase
				end
				next_s.deadtime_rising = deadtime_rising_i;
				next_s.deadtime_falling = deadtime_falling_i;
			end
			gdm_pkg::OP_BRAKE: begin
				// brake patterns still pass the dead time unit on every change
				case (gdm_pkg::gdm_brake_t'(brake_pattern_i))
					gdm_pkg::BRK_ALL_LOW: begin
						next_s.req_lo = 3'h7;
					end
					gdm_pkg::BRK_ALL_HIGH: begin
						next_s.req_hi = 3'h7;
					end
					gdm_pkg::BRK_ALTERNATE: begin
						next_s.req_hi = {3{alt_phase}};
						next_s.req_lo = {3{~alt_phase}};
					end
					default: begin
						next_s.req_hi = 3'h0;
						next_s.req_lo = 3'h0;
					end
				endcase
			end
			default: begin
				next_s.req_hi = 3'h0;
				next_s.req_lo = 3'h0;
			end
		endcase
	end

	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			s <= '{op: gdm_pkg::OP_IDLE, req_hi: gdm_pkg::GATES_RST,
				req_lo: gdm_pkg::GATES_RST, deadtime_rising: gdm_pkg::DT_CNT_RST,
				deadtime_falling: gdm_pkg::DT_CNT_RST, step: 4'hf};
		end else begin
			s <= next_s;
		end
	end

	assign gate_if.req_hi = s.req_hi;
	assign gate_if.req_lo = s.req_lo;
	assign gate_if.deadtime_rising = s.deadtime_rising;
	assign gate_if.deadtime_falling = s.deadtime_falling;

	gdm_brake_alt u_brake_alt (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n),
		.run_i((s.op == gdm_pkg::OP_BRAKE) &&
			(brake_pattern_i == gdm_pkg::BRK_ALTERNATE)),
		.alt_phase_o(alt_phase)
	);

	gdm_deadtime u_deadtime (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n),
		.gate(gate_if.drv)
	);

	assign high_gate_out_o = gate_if.gate_hi;
	assign low_gate_out_o = gate_if.gate_lo;
	assign phase_node_float_o = gate_if.node_float;
	assign op_state_o = s.op;
	assign comm_step_o = s.step;
endmodule

// *** verif/gdm_mcu_model.sv ***
// controller model that drives the pwm and brake inputs
`timescale 1ns/10ps
module gdm_mcu_model (
	input wire logic clk_i,
	output logic [2:0] hi_o,
	output logic [2:0] lo_o,
	output logic brk_n_o
);
	// unused phases start and stay low so their gates stay off, except in three input mode where their low gates turn on
	initial begin
		hi_o = 3'h0;
		lo_o = 3'h0;
		brk_n_o = 1'b1;
	end
	task put(input logic [2:0] h, input logic [2:0] l, input logic b);
		@(negedge clk_i);
		hi_o = h;
		lo_o = l;
		brk_n_o = b;
	endtask
	// both sides off for dt cycles before the new side comes on
	task comp_pair(input int p, input logic v, input int dt);
		@(negedge clk_i);
		hi_o[p] = 1'b0;
		lo_o[p] = 1'b0;
		repeat (dt) @(negedge clk_i);
		hi_o[p] = v;
		lo_o[p] = !v;
	endtask
	// c is the twelve step bit, toggled by the caller per 30 degrees
	task step12(input logic p, input logic [2:0] code, input logic c);
		@(negedge clk_i);
		hi_o = {c, code[1], p};
		lo_o = {1'b0, code[0], code[2]};
	endtask
endmodule

// *** verif/gdm_mode_decoder_asserts.sv ***
// port assertions of the gate drive mode decoder
`timescale 1ns/10ps
module gdm_mode_decoder_asserts (
	input wire logic clk_sys_i,
	input wire logic nrst_i,
	input wire logic [2:0] drive_mode_select_i,
	input wire logic brake_request_n_i,
	input wire logic [1:0] brake_pattern_i,
	input wire logic [7:0] deadtime_rising_i,
	input wire logic [7:0] deadtime_falling_i,
	input wire logic [2:0] high_side_pwm_in_i,
	input wire logic [2:0] low_side_pwm_in_i,
	input wire logic [2:0] high_gate_out_o,
	input wire logic [2:0] low_gate_out_o,
	input wire logic [2:0] phase_node_float_o,
	input wire logic [2:0] op_state_o
);
	logic [1:0] up;
	logic [7:0] hi_off;
	logic [7:0] lo_off;
	wire logic run = (up == 2'h3) && brake_request_n_i;
	wire logic six = drive_mode_select_i == gdm_pkg::MODE_SIX;
	wire logic three = drive_mode_select_i == gdm_pkg::MODE_THREE;
	// outputs are held for two synchroniser edges after reset, so wait three
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			up <= 2'h0;
			hi_off <= 8'h00;
			lo_off <= 8'h00;
		end else begin
			up <= (up == 2'h3) ? up : up + 2'h1;
			hi_off <= high_gate_out_o[0] ? 8'h00 : hi_off + 8'(hi_off != 8'hff);
			lo_off <= low_gate_out_o[0] ? 8'h00 : lo_off + 8'(lo_off != 8'hff);
		end
	end
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!nrst_i);
	sequence six_a_hi;
		(run && six && high_side_pwm_in_i[0] && !low_side_pwm_in_i[0]) [*8];
	endsequence
	sequence six_a_lo;
		(run && six && !high_side_pwm_in_i[0] && low_side_pwm_in_i[0]) [*8];
	endsequence
	sequence three_b_lo;
		(run && three && !high_side_pwm_in_i[1] && !low_side_pwm_in_i[1]) [*8];
	endsequence
	chk_no_shoot: assert property ((high_gate_out_o & low_gate_out_o) == 3'h0)
		else $error("both gates of a phase on");
	chk_float_both: assert property (phase_node_float_o == ~(high_gate_out_o | low_gate_out_o))
		else $error("float flag disagrees with gates");
	chk_six_high: assert property (six_a_hi |-> high_gate_out_o[0] && !low_gate_out_o[0])
		else $error("six input high decode wrong");
	chk_six_low: assert property (six_a_lo |-> low_gate_out_o[0] && !high_gate_out_o[0])
		else $error("six input low decode wrong");
	chk_six_gap: assert property ($rose(low_gate_out_o[0]) && six && run |->
		hi_off >= gdm_pkg::DT_MIN_CYC) else $error("six input dead time too short");
	chk_rise_gap: assert property ($rose(high_gate_out_o[0]) && three && run |->
		lo_off >= deadtime_rising_i) else $error("rising dead time too short");
	chk_fall_gap: assert property ($rose(low_gate_out_o[0]) && three && run |->
		hi_off >= deadtime_falling_i) else $error("falling dead time too short");
	chk_three_comp: assert property (three_b_lo |-> low_gate_out_o[1] && !high_gate_out_o[1])
		else $error("three input low side not complement");
	chk_three_float: assert property ((run && three && low_side_pwm_in_i[2]) [*3]
		|-> phase_node_float_o[2]) else $error("three input phase not floated");
	chk_brake_op: assert property ((up == 2'h3 && !brake_request_n_i) [*3] |->
		op_state_o == 3'h5) else $error("brake not taken");
	chk_brake_low: assert property ((up == 2'h3 && !brake_request_n_i &&
		brake_pattern_i == gdm_pkg::BRK_ALL_LOW) [*8] |-> high_gate_out_o == 3'h0)
		else $error("low brake left a high gate on");
	chk_brake_hiz: assert property ((up == 2'h3 && !brake_request_n_i &&
		brake_pattern_i == gdm_pkg::BRK_HIZ) [*4] |-> (high_gate_out_o | low_gate_out_o) == 3'h0)
		else $error("hi-z brake left a gate on");
endmodule
bind gdm_mode_decoder gdm_mode_decoder_asserts chk (.*);

// *** verif/tb.sv ***
// self-checking bench of the gate drive mode decoder
`timescale 1ns/10ps
module tb;
	logic clk_sys_i;
	logic nrst_i;
	logic [2:0] mode;
	logic [1:0] pat;
	logic fw;
	logic [7:0] dtr;
	logic [7:0] dtf;
	logic [2:0] hin;
	logic [2:0] lin;
	logic brk_n;
	logic [2:0] hg;
	logic [2:0] lg;
	logic [2:0] fl;
	logic [2:0] op;
	logic [3:0] step;
	int errors;
	int cmp_count;
	gdm_mcu_model mcu (.clk_i(clk_sys_i), .hi_o(hin), .lo_o(lin), .brk_n_o(brk_n));
	gdm_mode_decoder uut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .drive_mode_select_i(mode),
		.brake_request_n_i(brk_n), .brake_pattern_i(pat), .freewheel_select_i(fw),
		.deadtime_rising_i(dtr), .deadtime_falling_i(dtf), .high_side_pwm_in_i(hin),
		.low_side_pwm_in_i(lin), .high_gate_out_o(hg), .low_gate_out_o(lg),
		.phase_node_float_o(fl), .op_state_o(op), .comm_step_o(step));
	initial begin
		clk_sys_i = 1'b0;
		forever #4 clk_sys_i = ~clk_sys_i;
	end
	task final_report;
		$display("errors %0d comparisons %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task cyc(input int n);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask
	task cmp_gates(input logic [2:0] eh, input logic [2:0] el);
		cmp_count++;
		if (hg !== eh || lg !== el) begin
			errors++;
			$display("unexpected at %0t: gates %b/%b want %b/%b", $time, hg, lg, eh, el);
		end
	endtask
	task cmp_val(input logic [3:0] got, input logic [3:0] exp);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: value %h want %h", $time, got, exp);
		end
	endtask
	task setm(input logic [2:0] m, input logic [1:0] p);
		@(negedge clk_sys_i);
		mode = m;
		pat = p;
	endtask
	task sgl(input logic f, input logic p, input logic [2:0] c, input logic s,
		input logic [2:0] eh, input logic [2:0] el, input logic [3:0] es);
		mcu.step12(p, c, s);
		fw = f;
		cyc(16);
		cmp_gates(eh, el);
		cmp_val(step, es);
	endtask
	// a hang ends the run through the same report
	initial begin
		repeat (20000) @(posedge clk_sys_i);
		errors++;
		final_report;
	end
	initial begin
		errors = 0;
		cmp_count = 0;
		nrst_i = 1'b0;
		mode = gdm_pkg::MODE_SIX;
		pat = 2'h0;
		fw = 1'b1;
		dtr = 8'h02;
		dtf = 8'h06;
		repeat (12) @(negedge clk_sys_i);
		cmp_gates(3'h0, 3'h0);
		cmp_val({1'b0, fl}, 4'h7);
		cmp_val(step, 4'hf);
		nrst_i = 1'b1;
		cyc(4);
		mcu.put(3'h1, 3'h0, 1'b1);
		cyc(12);
		cmp_gates(3'h1, 3'h0);
		cmp_val({1'b0, op}, 4'h1);
		mcu.put(3'h0, 3'h2, 1'b1);
		cyc(12);
		cmp_gates(3'h0, 3'h2);
		mcu.put(3'h4, 3'h4, 1'b1);
		cyc(12);
		cmp_gates(3'h0, 3'h0);
		cmp_val({1'b0, fl}, 4'h7);
		// overlapping inputs: the low gate must still wait out the floor
		mcu.put(3'h1, 3'h0, 1'b1);
		cyc(12);
		mcu.put(3'h1, 3'h1, 1'b1);
		mcu.put(3'h0, 3'h1, 1'b1);
		cyc(3);
		cmp_gates(3'h0, 3'h0);
		cyc(12);
		cmp_gates(3'h0, 3'h1);
		mcu.comp_pair(0, 1'b1, 4);
		cyc(12);
		cmp_gates(3'h1, 3'h0);
		setm(gdm_pkg::MODE_THREE, 2'h0);
		mcu.put(3'h0, 3'h0, 1'b1);
		cyc(12);
		cmp_gates(3'h0, 3'h7);
		cmp_val({1'b0, op}, 4'h2);
		mcu.put(3'h1, 3'h0, 1'b1);
		cyc(3);
		cmp_gates(3'h0, 3'h6);
		cyc(12);
		cmp_gates(3'h1, 3'h6);
		mcu.put(3'h0, 3'h0, 1'b1);
		cyc(5);
		cmp_gates(3'h0, 3'h6);
		cyc(12);
		cmp_gates(3'h0, 3'h7);
		mcu.put(3'h0, 3'h4, 1'b1);
		cyc(12);
		cmp_gates(3'h0, 3'h3);
		setm(gdm_pkg::MODE_SINGLE, 2'h0);
		sgl(1'b1, 1'b1, gdm_pkg::COMM_AB, 1'b0, 3'h1, 3'h2, 4'h0);
		cmp_val({1'b0, op}, 4'h3);
		sgl(1'b0, 1'b0, gdm_pkg::COMM_AB, 1'b0, 3'h0, 3'h3, 4'h0);
		sgl(1'b1, 1'b1, gdm_pkg::COMM_CA, 1'b1, 3'h4, 3'h3, 4'h3);
		sgl(1'b1, 1'b1, gdm_pkg::COMM_ALIGN, 1'b0, 3'h1, 3'h6, 4'he);
		sgl(1'b1, 1'b1, gdm_pkg::COMM_STOP, 1'b0, 3'h0, 3'h0, 4'hf);
		// hall variants decode outside this block, so their gates stay off
		for (int i = 3; i < 5; i++) begin
			setm(3'(i), 2'h0);
			mcu.put(3'h7, 3'h0, 1'b1);
			cyc(12);
			cmp_gates(3'h0, 3'h0);
			cmp_val({1'b0, op}, 4'h4);
		end
		setm(gdm_pkg::MODE_SIX, 2'h0);
		mcu.put(3'h1, 3'h0, 1'b0);
		cyc(16);
		cmp_gates(3'h0, 3'h7);
		cmp_val({1'b0, op}, 4'h5);
		setm(gdm_pkg::MODE_SIX, 2'h1);
		cyc(16);
		cmp_gates(3'h7, 3'h0);
		setm(gdm_pkg::MODE_SIX, 2'h3);
		cyc(12);
		cmp_gates(3'h0, 3'h0);
		mcu.put(3'h1, 3'h0, 1'b1);
		cyc(12);
		setm(gdm_pkg::MODE_SIX, 2'h2);
		mcu.put(3'h1, 3'h0, 1'b0);
		cyc(14);
		cmp_gates(3'h0, 3'h7);
		cyc(1290);
		cmp_gates(3'h7, 3'h0);
		final_report;
	end
endmodule
